// file: rtl/i2cmx_pkg.sv
// Shared constants and types for the two-wire mux control target
package i2cmx_pkg;

  // ----------------------------------------------------------------------
  // Framing
  // ----------------------------------------------------------------------
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] BIT_CNT_LAST = 4'h8;
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [6:0] TARGET_ADDR_DEFAULT = 7'h70;
  localparam int RW_BIT = 0;

  // ----------------------------------------------------------------------
  // Control byte layout
  // ----------------------------------------------------------------------
  localparam int CTRL_ENABLE_BIT = 2;
  localparam int CTRL_SEL_HI = 1;
  localparam int CTRL_SEL_LO = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] SEL_CHAN0 = 2'h0;
  localparam logic [1:0] SEL_CHAN1 = 2'h1;

  // ----------------------------------------------------------------------
  // Synchroniser depth
  // ----------------------------------------------------------------------
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_AACK  = 3'b010,
    ST_WRITE = 3'b011,
    ST_WACK  = 3'b100,
    ST_READ  = 3'b101,
    ST_RACK  = 3'b110
  } i2cmx_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } i2cmx_pins_t;

  typedef struct packed {
    logic chan0;
    logic chan1;
  } i2cmx_chan_t;

endpackage

// file: rtl/i2cmx_sync.sv
// Two-flop level synchroniser, one lane per bit
`timescale 1ns/1ps
module i2cmx_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,               // Destination clock
  input wire logic [WIDTH-1:0] din,   // Asynchronous levels
  output logic [WIDTH-1:0] dout       // Synchronised levels
);

  // Elaboration-time refusal of an empty synchroniser
  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("i2cmx_sync: WIDTH must be at least 1");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_lane
      logic meta;
      always_ff @(posedge clk) begin
        meta <= din[g];
        dout[g] <= meta;
      end
    end
  endgenerate

endmodule

// file: rtl/i2cmx_target.sv
// Two-wire target interface holding the channel-select control byte
`timescale 1ns/1ps
module i2cmx_target #(
  parameter logic [6:0] TARGET_ADDR = i2cmx_pkg::TARGET_ADDR_DEFAULT
) (
  input wire logic clk,          // System clock, 250 MHz
  input wire logic sys_rst,      // Synchronous reset, active high
  input wire logic link_scl,     // Bus clock from master, link domain clock
  input wire logic sda_in,       // Data line level seen at the pin
  output logic sda_out,          // Data line drive value, always low
  output logic sda_oe_n,         // Data line drive enable, low drives
  output logic chan0_en,         // Downstream channel pair 0 connected
  output logic chan1_en,         // Downstream channel pair 1 connected
  output logic [7:0] ctrl_byte   // Control byte now in effect
);

  // Elaboration-time refusal of the general call address
  generate
    if (TARGET_ADDR == 7'h00) begin : g_bad_addr
      $error("i2cmx_target: general call address is not a valid target address");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Decode of control byte to channel enables
  // ----------------------------------------------------------------------
  function automatic i2cmx_pkg::i2cmx_chan_t decode_ctrl(input logic [7:0] b);
    i2cmx_pkg::i2cmx_chan_t c;
    c.chan0 = 1'b0;
    c.chan1 = 1'b0;
    if (b[i2cmx_pkg::CTRL_ENABLE_BIT]) begin
      c.chan0 = (b[i2cmx_pkg::CTRL_SEL_HI:i2cmx_pkg::CTRL_SEL_LO] == i2cmx_pkg::SEL_CHAN0);
      c.chan1 = (b[i2cmx_pkg::CTRL_SEL_HI:i2cmx_pkg::CTRL_SEL_LO] == i2cmx_pkg::SEL_CHAN1);
    end
    return c;
  endfunction

  // ----------------------------------------------------------------------
  // Link domain: bit capture on rising bus clock
  // ----------------------------------------------------------------------
  // The captured word is read by the system domain only after the synced
  // falling edge that follows the eighth bit, when it is stable.
  logic [7:0] link_shift;

  always_ff @(posedge link_scl) begin
    link_shift <= {link_shift[6:0], sda_in};
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  i2cmx_pkg::i2cmx_pins_t pins_raw;
  i2cmx_pkg::i2cmx_pins_t pins_s;
  i2cmx_pkg::i2cmx_pins_t pins_d;

  assign pins_raw.scl = link_scl;
  assign pins_raw.sda = sda_in;

  i2cmx_sync #(
    .WIDTH($bits(i2cmx_pkg::i2cmx_pins_t))
  ) u_sync (
    .clk(clk),
    .din(pins_raw),
    .dout(pins_s)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pins_d <= '1;
    end else begin
      pins_d <= pins_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise = pins_s.scl & ~pins_d.scl;
  assign scl_fall = ~pins_s.scl & pins_d.scl;
  assign start_det = pins_s.scl & pins_d.scl & pins_d.sda & ~pins_s.sda;
  assign stop_det = pins_s.scl & pins_d.scl & ~pins_d.sda & pins_s.sda;

  // ----------------------------------------------------------------------
  // Framing state
  // ----------------------------------------------------------------------
  i2cmx_pkg::i2cmx_state_t state;
  logic [3:0] bit_cnt;
  logic read_mode;
  logic [7:0] tx_shift;
  logic master_nack;
  logic [7:0] ctrl_pending;
  logic pending_valid;
  logic byte_done;
  logic addr_match;

  assign byte_done = scl_fall & (bit_cnt == i2cmx_pkg::BIT_CNT_LAST);
  assign addr_match = (link_shift[7:1] == TARGET_ADDR);

  // Bit counter: counts rising edges inside a byte, cleared per byte
  // The acknowledge pulse must not leave a count behind for the next byte
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bit_cnt <= i2cmx_pkg::BIT_CNT_ZERO;
    end else if (start_det || stop_det) begin
      bit_cnt <= i2cmx_pkg::BIT_CNT_ZERO;
    end else if (byte_done) begin
      bit_cnt <= i2cmx_pkg::BIT_CNT_ZERO;
    end else if (scl_fall && (state == i2cmx_pkg::ST_AACK || state == i2cmx_pkg::ST_WACK ||
                              state == i2cmx_pkg::ST_RACK)) begin
      bit_cnt <= i2cmx_pkg::BIT_CNT_ZERO;
    end else if (scl_rise && bit_cnt != i2cmx_pkg::BIT_CNT_LAST) begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // Main sequencer and data line drive
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= i2cmx_pkg::ST_IDLE;
      sda_oe_n <= 1'b1;
      read_mode <= 1'b0;
      tx_shift <= i2cmx_pkg::CTRL_RESET;
    end else if (start_det) begin
      state <= i2cmx_pkg::ST_ADDR;
      sda_oe_n <= 1'b1;
    end else if (stop_det) begin
      state <= i2cmx_pkg::ST_IDLE;
      sda_oe_n <= 1'b1;
    end else begin
      case (state)
        i2cmx_pkg::ST_IDLE: begin
          sda_oe_n <= 1'b1;
        end
        i2cmx_pkg::ST_ADDR: begin
          if (byte_done) begin
            if (addr_match) begin
              sda_oe_n <= 1'b0;
              read_mode <= link_shift[i2cmx_pkg::RW_BIT];
              state <= i2cmx_pkg::ST_AACK;
            end else begin
              state <= i2cmx_pkg::ST_IDLE;
            end
          end
        end
        i2cmx_pkg::ST_AACK: begin
          if (scl_fall) begin
            if (read_mode) begin
              tx_shift <= ctrl_byte;
              sda_oe_n <= ctrl_byte[7];
              state <= i2cmx_pkg::ST_READ;
            end else begin
              sda_oe_n <= 1'b1;
              state <= i2cmx_pkg::ST_WRITE;
            end
          end
        end
        i2cmx_pkg::ST_WRITE: begin
          if (byte_done) begin
            sda_oe_n <= 1'b0;
            state <= i2cmx_pkg::ST_WACK;
          end
        end
        i2cmx_pkg::ST_WACK: begin
          if (scl_fall) begin
            sda_oe_n <= 1'b1;
            state <= i2cmx_pkg::ST_WRITE;
          end
        end
        i2cmx_pkg::ST_READ: begin
          if (byte_done) begin
            sda_oe_n <= 1'b1;
            state <= i2cmx_pkg::ST_RACK;
          end else if (scl_fall && bit_cnt != i2cmx_pkg::BIT_CNT_ZERO) begin
            tx_shift <= {tx_shift[6:0], 1'b0};
            sda_oe_n <= tx_shift[6];
          end
        end
        i2cmx_pkg::ST_RACK: begin
          if (scl_fall) begin
            if (master_nack) begin
              sda_oe_n <= 1'b1;
              state <= i2cmx_pkg::ST_IDLE;
            end else begin
              tx_shift <= ctrl_byte;
              sda_oe_n <= ctrl_byte[7];
              state <= i2cmx_pkg::ST_READ;
            end
          end
        end
        default: begin
          state <= i2cmx_pkg::ST_IDLE;
          sda_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // Master acknowledge sampled while the bus clock is high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      master_nack <= 1'b1;
    end else if (state == i2cmx_pkg::ST_RACK && scl_rise) begin
      master_nack <= pins_s.sda;
    end
  end

  // Open-drain drive value, registered so the output comes from a flop
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Control byte: staged on write, committed at stop
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_pending <= i2cmx_pkg::CTRL_RESET;
      pending_valid <= 1'b0;
    end else if (state == i2cmx_pkg::ST_WRITE && byte_done) begin
      ctrl_pending <= link_shift;
      pending_valid <= 1'b1;
    end else if (stop_det) begin
      pending_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_byte <= i2cmx_pkg::CTRL_RESET;
    end else if (stop_det && pending_valid) begin
      ctrl_byte <= ctrl_pending;
    end
  end

  // ----------------------------------------------------------------------
  // Channel enables
  // ----------------------------------------------------------------------
  i2cmx_pkg::i2cmx_chan_t chan;

  assign chan = decode_ctrl(ctrl_byte);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      chan0_en <= 1'b0;
      chan1_en <= 1'b0;
    end else begin
      chan0_en <= chan.chan0;
      chan1_en <= chan.chan1;
    end
  end

endmodule

// file: test/i2cmx_target_checker.sv
// Port assertions for the mux control target
`timescale 1ns/1ps
module i2cmx_target_checker (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic link_scl, // Bus clock
  input wire logic sda_in, // Data line level
  input wire logic sda_out, // Drive value
  input wire logic sda_oe_n, // Drive enable, low drives
  input wire logic chan0_en, // Channel 0 connected
  input wire logic chan1_en, // Channel 1 connected
  input wire logic [7:0] ctrl_byte // Control byte
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_reset_state: assert property ($past(sys_rst) |-> ctrl_byte == 8'h00 && sda_oe_n)
    else $error("reset state wrong");
  chk_chan_onehot: assert property (!(chan0_en && chan1_en))
    else $error("both channels on");
  chk_chan0_map: assert property (chan0_en == ($past(ctrl_byte[2:0]) == 3'h4))
    else $error("channel 0 decode wrong");
  chk_chan1_map: assert property (chan1_en == ($past(ctrl_byte[2:0]) == 3'h5))
    else $error("channel 1 decode wrong");
  chk_commit_at_stop: assert property (!$stable(ctrl_byte) |-> link_scl && sda_in)
    else $error("control byte changed outside stop");
  chk_sda_scl_low: assert property (!$stable(sda_oe_n) |-> !link_scl)
    else $error("data drive changed while clock high");
  chk_ack_hold: assert property ($rose(link_scl) && !sda_oe_n |=> !sda_oe_n [*4])
    else $error("low drive not held through clock high");
  chk_stop_release: assert property ($rose(sda_in) && link_scl |=> sda_oe_n [*8])
    else $error("data line driven after stop");
  chk_drive_value: assert property (!sda_oe_n |-> !sda_out)
    else $error("data line driven high");
endmodule

bind i2cmx_target i2cmx_target_checker u_chk (.clk(clk), .sys_rst(sys_rst),
  .link_scl(link_scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .chan0_en(chan0_en), .chan1_en(chan1_en), .ctrl_byte(ctrl_byte));

// file: test/i2cmx_master_model.sv
// Bus master model driving the two-wire link
`timescale 1ns/1ps
module i2cmx_master_model (
  input wire logic sda, // Resolved data line
  output logic scl, // Bus clock, idle high
  output logic sda_low // Pulls the data line low
);
  logic tick = 1'b0;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    #1.3;
    forever #3 tick = ~tick;
  end
  task automatic wait_ticks(input int n);
    repeat (n) @(posedge tick);
  endtask
  task automatic start_cond();
    wait_ticks(6);
    sda_low = 1'b1;
    wait_ticks(6);
    scl = 1'b0;
  endtask
  task automatic stop_cond();
    wait_ticks(1);
    sda_low = 1'b1;
    wait_ticks(5);
    scl = 1'b1;
    wait_ticks(6);
    sda_low = 1'b0;
    wait_ticks(6);
  endtask
  // Data held one tick past the fall so it never looks like start or stop
  task automatic bit_slot(input logic b, output logic r);
    wait_ticks(1);
    sda_low = ~b;
    wait_ticks(5);
    scl = 1'b1;
    wait_ticks(3);
    r = sda;
    wait_ticks(3);
    scl = 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_slot(d[i], r);
    bit_slot(1'b1, r);
    ack = ~r;
  endtask
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
    bit_slot(~ack, r);
  endtask
endmodule

// file: test/i2cmx_target_tb_top.sv
// Self-checking bench for the mux control target
`timescale 1ns/1ps
module i2cmx_target_tb_top;
  localparam logic [6:0] ADDR = i2cmx_pkg::TARGET_ADDR_DEFAULT;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic scl, sda_low, sda_oe_n, sda_out, chan0_en, chan1_en;
  logic [7:0] ctrl_byte;
  wire logic sda_line;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  always #2 clk = ~clk;
  // Pull-up resolution of the open-drain data line
  assign sda_line = sda_oe_n & ~sda_low;
  i2cmx_target u_dut (.clk(clk), .sys_rst(sys_rst), .link_scl(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .chan0_en(chan0_en), .chan1_en(chan1_en),
    .ctrl_byte(ctrl_byte));
  i2cmx_master_model u_master (.sda(sda_line), .scl(scl), .sda_low(sda_low));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    if (n_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic do_reset();
    @(negedge clk) sys_rst = 1'b1;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    check("released", {7'h00, sda_oe_n}, 8'h01);
    check("drive value", {7'h00, sda_out}, 8'h00);
    check("chans", {6'h00, chan0_en, chan1_en}, 8'h00);
    check("ctrl", ctrl_byte, 8'h00);
    repeat (4) @(negedge clk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] data[$], input logic ack_exp);
    logic ack;
    logic [7:0] old;
    old = ctrl_byte;
    u_master.start_cond();
    u_master.send_byte({a, 1'b0}, ack);
    check("addr ack", {7'h00, ack}, {7'h00, ack_exp});
    foreach (data[i]) begin
      u_master.send_byte(data[i], ack);
      check("data ack", {7'h00, ack}, {7'h00, ack_exp});
    end
    check("held", ctrl_byte, old);
    u_master.stop_cond();
    repeat (4) @(negedge clk);
  endtask
  task automatic t_decode();
    logic [7:0] vals[8] = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'hFC, 8'hFD, 8'hFB};
    foreach (vals[i]) begin
      wr(ADDR, '{vals[i]}, 1'b1);
      check("ctrl", ctrl_byte, vals[i]);
      check("chan0", {7'h00, chan0_en}, {7'h00, vals[i][2:0] == 3'h4});
      check("chan1", {7'h00, chan1_en}, {7'h00, vals[i][2:0] == 3'h5});
    end
  endtask
  task automatic t_write_multi();
    wr(ADDR, '{8'h04, 8'h00, 8'h05}, 1'b1);
    check("last byte", ctrl_byte, 8'h05);
    check("chans", {6'h00, chan0_en, chan1_en}, 8'h01);
  endtask
  task automatic t_addr_miss();
    wr(ADDR ^ 7'h01, '{8'h04}, 1'b0);
    check("ignored", ctrl_byte, 8'h05);
  endtask
  task automatic t_read();
    logic ack;
    logic [7:0] d;
    u_master.start_cond();
    u_master.send_byte({ADDR, 1'b1}, ack);
    check("read ack", {7'h00, ack}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      u_master.recv_byte(i < 2, d);
      check("read data", d, 8'h05);
    end
    #20;
    check("nack release", {7'h00, sda_oe_n}, 8'h01);
    u_master.stop_cond();
    check("read keeps", ctrl_byte, 8'h05);
  endtask
  initial begin
    do_reset();
    t_decode();
    t_write_multi();
    t_addr_miss();
    t_read();
    do_reset();
    summarize();
  end
endmodule
